// [rtl/iocs_pkg.sv]
package iocs_pkg;
   localparam int CLK_MHZ = 10;
   localparam int CNT_W = 16;

   localparam logic [7:0] OSC_CONTROL_OFFSET = 8'h00;
   localparam logic [7:0] OSC_STATUS_OFFSET = 8'h04;

   localparam int CTRL_PLL_EN_BIT = 7;
   localparam int CTRL_FREQ_LSB = 3;
   localparam int CTRL_SCS_LSB = 0;
   localparam int STAT_PLL_READY_BIT = 6;
   localparam int STAT_CFG_SRC_BIT = 5;
   localparam int STAT_HF_READY_BIT = 4;
   localparam int STAT_HF_LOCKED_BIT = 3;
   localparam int STAT_MF_READY_BIT = 2;
   localparam int STAT_LF_READY_BIT = 1;
   localparam int STAT_HF_STABLE_BIT = 0;

   localparam logic SW_PLL_RESET = 1'b0;
   localparam logic [3:0] FREQ_RESET = 4'h7;
   localparam logic [1:0] SCS_RESET = 2'h0;

   localparam logic [3:0] FREQ_PLL_CAPABLE = 4'he;
   localparam logic [3:0] FREQ_HF_SLOWEST = 4'h3;
   localparam logic [3:0] FREQ_MF_SLOWEST = 4'h2;
   localparam logic [1:0] SCS_CONFIG = 2'h0;
   localparam logic [1:0] SCS_RESERVED = 2'h1;
   localparam logic [1:0] CFG_SRC_INTERNAL = 2'h0;

   // least times round up to whole aclk cycles
   localparam int HF_START_NS = 2000;
   localparam int HF_START_CYC = (HF_START_NS * CLK_MHZ + 999) / 1000;
   localparam int LF_START_CYC = 1;
   localparam int EXT_WAKE_CYC = 2;
   localparam int PLL_LOCK_US = 2000;
   localparam int PLL_LOCK_CYC = PLL_LOCK_US * CLK_MHZ;
   localparam int WARMUP_CYC_DEFAULT = 16;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic ext;
      logic hf;
      logic mf;
      logic lf;
      logic pll;
   } iocs_levels_t;

   typedef struct packed {
      logic hf;
      logic mf;
      logic lf;
      logic pll;
   } iocs_osc_en_t;

   typedef enum logic [2:0] {
      SRC_LF = 3'h0,
      SRC_MF = 3'h1,
      SRC_HF = 3'h2,
      SRC_PLL = 3'h3,
      SRC_EXT = 3'h4
   } iocs_src_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_STARTUP = 3'h1,
      ST_WAIT_FALL = 3'h3,
      ST_HOLD_LOW = 3'h2,
      ST_STATUS = 3'h6,
      ST_DONE = 3'h7
   } iocs_state_t;

   function automatic logic iocs_addr_mapped(input logic [7:0] addr);
      return (addr == OSC_CONTROL_OFFSET) || (addr == OSC_STATUS_OFFSET);
   endfunction
endpackage

// [rtl/iocs_axil_slave.sv]
`timescale 1ns/10ps
module iocs_axil_slave (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic wr_en,
   output logic [7:0] wr_addr,
   output logic [7:0] wr_data,
   input wire logic [7:0] rd_data
);
   import iocs_pkg::*;

   logic aw_have_ff, nxt_aw_have;
   logic w_have_ff, nxt_w_have;
   logic [7:0] addr_ff, nxt_addr;
   logic [7:0] data_ff, nxt_data;
   logic strb_ff, nxt_strb;
   logic bvalid_ff, nxt_bvalid;
   logic [1:0] bresp_ff, nxt_bresp;
   logic rvalid_ff, nxt_rvalid;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [1:0] rresp_ff, nxt_rresp;
   logic wr_en_ff, nxt_wr_en;

   //////////////////////////////////////////////////////////////////////////////
   // address and data are taken in either order; the response waits for both
   always_comb begin
      nxt_aw_have = aw_have_ff;
      nxt_w_have = w_have_ff;
      nxt_addr = addr_ff;
      nxt_data = data_ff;
      nxt_strb = strb_ff;
      nxt_bvalid = bvalid_ff;
      nxt_bresp = bresp_ff;
      nxt_wr_en = 1'b0;
      if (awvalid && !aw_have_ff) begin
         nxt_aw_have = 1'b1;
         nxt_addr = awaddr;
      end
      if (wvalid && !w_have_ff) begin
         nxt_w_have = 1'b1;
         nxt_data = wdata[7:0];
         nxt_strb = wstrb[0];
      end
      if (aw_have_ff && w_have_ff && !bvalid_ff) begin
         nxt_bvalid = 1'b1;
         nxt_bresp = iocs_addr_mapped(addr_ff) ? RESP_OKAY : RESP_SLVERR;
         nxt_wr_en = iocs_addr_mapped(addr_ff) && strb_ff;
      end
      if (bvalid_ff && bready) begin
         nxt_bvalid = 1'b0;
         nxt_aw_have = 1'b0;
         nxt_w_have = 1'b0;
      end
   end

   // read data is sampled at the address handshake, one cycle to rvalid
   always_comb begin
      nxt_rvalid = rvalid_ff;
      nxt_rdata = rdata_ff;
      nxt_rresp = rresp_ff;
      if (arvalid && !rvalid_ff) begin
         nxt_rvalid = 1'b1;
         nxt_rdata = {24'h000000, iocs_addr_mapped(araddr) ? rd_data : 8'h00};
         nxt_rresp = iocs_addr_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_ff && rready) begin
         nxt_rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_ff <= 1'b0;
         w_have_ff <= 1'b0;
         addr_ff <= 8'h00;
         data_ff <= 8'h00;
         strb_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h00000000;
         rresp_ff <= RESP_OKAY;
         wr_en_ff <= 1'b0;
      end else begin
         aw_have_ff <= nxt_aw_have;
         w_have_ff <= nxt_w_have;
         addr_ff <= nxt_addr;
         data_ff <= nxt_data;
         strb_ff <= nxt_strb;
         bvalid_ff <= nxt_bvalid;
         bresp_ff <= nxt_bresp;
         rvalid_ff <= nxt_rvalid;
         rdata_ff <= nxt_rdata;
         rresp_ff <= nxt_rresp;
         wr_en_ff <= nxt_wr_en;
      end
   end

   assign awready = !aw_have_ff;
   assign wready = !w_have_ff;
   assign bvalid = bvalid_ff;
   assign bresp = bresp_ff;
   assign arready = !rvalid_ff;
   assign rvalid = rvalid_ff;
   assign rdata = rdata_ff;
   assign rresp = rresp_ff;
   assign wr_en = wr_en_ff;
   assign wr_addr = addr_ff;
   assign wr_data = data_ff;
endmodule // iocs_axil_slave

// [rtl/iocs_clock_select.sv]
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/10ps
module iocs_clock_select #(
   parameter int PLL_LOCK_CYCLES = iocs_pkg::PLL_LOCK_CYC,
   parameter int WARMUP_CYCLES = iocs_pkg::WARMUP_CYC_DEFAULT
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic [1:0] config_clock_source,
   input wire logic config_pll_enable,
   input wire logic sleep_mode,
   input wire iocs_pkg::iocs_levels_t osc_levels,
   output logic sys_clk_ff,
   output iocs_pkg::iocs_osc_en_t osc_enable_ff,
   output logic [3:0] postscale_sel_ff,
   output iocs_pkg::iocs_src_t active_src_ff,
   output logic switch_busy_ff
);
   import iocs_pkg::*;

   localparam logic [CNT_W-1:0] PLL_LOCK_N = CNT_W'(PLL_LOCK_CYCLES);
   localparam logic [CNT_W-1:0] WARMUP_N = CNT_W'(WARMUP_CYCLES);

   logic wr_en;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic [7:0] rd_data;

   logic software_pll_enable_ff, nxt_software_pll_enable;
   logic [3:0] internal_freq_select_ff, nxt_internal_freq_select;
   logic [1:0] system_clock_select_ff, nxt_system_clock_select;

   iocs_state_t state_ff, nxt_state;
   iocs_src_t tgt_src_ff, nxt_tgt_src;
   iocs_src_t nxt_active_src;
   iocs_src_t want_src;
   iocs_osc_en_t nxt_osc_enable;
   logic [3:0] tgt_freq_ff, nxt_tgt_freq;
   logic [3:0] nxt_postscale_sel;
   logic [2:0] run_ff, nxt_run;
   logic [CNT_W-1:0] cnt_ff, nxt_cnt;
   logic wake_pend_ff, nxt_wake_pend;
   logic live_ff, nxt_live;
   logic prev_new_ff, nxt_prev_new;
   logic nxt_sys_clk;
   logic nxt_switch_busy;
   logic pll_on;
   logic [CNT_W-1:0] pll_cnt_ff, nxt_pll_cnt;
   logic pll_ready_ff, nxt_pll_ready;
   logic old_level;
   logic new_level;

   //////////////////////////////////////////////////////////////////////////////
   // frequency field decode
   function automatic iocs_src_t freq_src(input logic [3:0] freq);
      if (freq[3:1] == 3'h0) begin
         return SRC_LF;
      end else if (freq == FREQ_MF_SLOWEST) begin
         return SRC_MF;
      end else if (freq == FREQ_HF_SLOWEST) begin
         return SRC_HF;
      end else if (!freq[3]) begin
         return SRC_MF;
      end
      return SRC_HF;
   endfunction

   function automatic logic [2:0] src_osc(input iocs_src_t src);
      unique case (src)
         SRC_LF: return 3'h1;
         SRC_MF: return 3'h2;
         SRC_HF, SRC_PLL: return 3'h4;
         default: return 3'h0;
      endcase
   endfunction

   function automatic logic src_level(input iocs_src_t src, input iocs_levels_t lv);
      unique case (src)
         SRC_LF: return lv.lf;
         SRC_MF: return lv.mf;
         SRC_HF: return lv.hf;
         SRC_PLL: return lv.pll;
         default: return lv.ext;
      endcase
   endfunction

   function automatic logic [CNT_W-1:0] start_cyc(input iocs_src_t src);
      unique case (src)
         SRC_LF: return CNT_W'(LF_START_CYC);
         SRC_EXT: return CNT_W'(0);
         default: return CNT_W'(HF_START_CYC);
      endcase
   endfunction

   //////////////////////////////////////////////////////////////////////////////
   iocs_axil_slave u_axil (
      .aclk(aclk),
      .aresetn(aresetn),
      .awvalid(awvalid),
      .awready(awready),
      .awaddr(awaddr),
      .wvalid(wvalid),
      .wready(wready),
      .wdata(wdata),
      .wstrb(wstrb),
      .bvalid(bvalid),
      .bready(bready),
      .bresp(bresp),
      .arvalid(arvalid),
      .arready(arready),
      .araddr(araddr),
      .rvalid(rvalid),
      .rready(rready),
      .rdata(rdata),
      .rresp(rresp),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .rd_data(rd_data)
   );

   always_comb begin
      nxt_software_pll_enable = software_pll_enable_ff;
      nxt_internal_freq_select = internal_freq_select_ff;
      nxt_system_clock_select = system_clock_select_ff;
      // only software writes the select field
      if (wr_en && (wr_addr == OSC_CONTROL_OFFSET)) begin
         nxt_software_pll_enable = wr_data[CTRL_PLL_EN_BIT];
         nxt_internal_freq_select = wr_data[CTRL_FREQ_LSB +: 4];
         nxt_system_clock_select = wr_data[CTRL_SCS_LSB +: 2];
      end
   end

   // bit 2 of the control word reads zero
   always_comb begin
      rd_data = 8'h00;
      if (araddr == OSC_CONTROL_OFFSET) begin
         rd_data[CTRL_PLL_EN_BIT] = software_pll_enable_ff;
         rd_data[CTRL_FREQ_LSB +: 4] = internal_freq_select_ff;
         rd_data[CTRL_SCS_LSB +: 2] = system_clock_select_ff;
      end else begin
         rd_data[STAT_PLL_READY_BIT] = pll_ready_ff;
         rd_data[STAT_CFG_SRC_BIT] = (active_src_ff == SRC_EXT);
         rd_data[STAT_HF_READY_BIT] = run_ff[2];
         rd_data[STAT_HF_LOCKED_BIT] = run_ff[2];
         rd_data[STAT_MF_READY_BIT] = run_ff[1];
         rd_data[STAT_LF_READY_BIT] = run_ff[0];
         rd_data[STAT_HF_STABLE_BIT] = run_ff[2];
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // config enable forces PLL on
   assign pll_on = config_pll_enable || software_pll_enable_ff;

   always_comb begin
      nxt_pll_cnt = pll_cnt_ff;
      nxt_pll_ready = pll_ready_ff;
      if (!pll_on || sleep_mode) begin
         nxt_pll_cnt = CNT_W'(0);
         nxt_pll_ready = 1'b0;
      end else if (pll_cnt_ff != PLL_LOCK_N) begin
         nxt_pll_cnt = pll_cnt_ff + CNT_W'(1);
      end else begin
         nxt_pll_ready = 1'b1;
      end
   end

   // select decode; reserved code keeps the running source
   always_comb begin
      want_src = active_src_ff;
      if (system_clock_select_ff == SCS_RESERVED) begin
         want_src = active_src_ff;
      end else if (system_clock_select_ff == SCS_CONFIG
                   && config_clock_source != CFG_SRC_INTERNAL) begin
         want_src = SRC_EXT;
      end else begin
         want_src = freq_src(internal_freq_select_ff);
         // PLL only via select 00 and 1110
         if (system_clock_select_ff == SCS_CONFIG && pll_on
             && internal_freq_select_ff == FREQ_PLL_CAPABLE) begin
            want_src = SRC_PLL;
         end
      end
   end

   assign old_level = live_ff && src_level(active_src_ff, osc_levels);
   assign new_level = src_level(tgt_src_ff, osc_levels);

   //////////////////////////////////////////////////////////////////////////////
   always_comb begin
      nxt_state = state_ff;
      nxt_tgt_src = tgt_src_ff;
      nxt_tgt_freq = tgt_freq_ff;
      nxt_active_src = active_src_ff;
      nxt_postscale_sel = postscale_sel_ff;
      nxt_run = run_ff;
      nxt_cnt = cnt_ff;
      nxt_wake_pend = wake_pend_ff;
      nxt_live = live_ff;
      nxt_prev_new = new_level;
      nxt_switch_busy = 1'b1;
      nxt_sys_clk = old_level;
      unique case (state_ff)
         ST_IDLE: begin
            nxt_switch_busy = 1'b0;
            if (sleep_mode) begin
               nxt_run = 3'h0;
               nxt_live = 1'b0;
               nxt_wake_pend = 1'b1;
               nxt_sys_clk = 1'b0;
            end else if (wake_pend_ff || want_src != active_src_ff
                         || (want_src != SRC_EXT
                             && internal_freq_select_ff != postscale_sel_ff)) begin
               nxt_state = ST_STARTUP;
               nxt_switch_busy = 1'b1;
               nxt_tgt_src = want_src;
               nxt_tgt_freq = internal_freq_select_ff;
               nxt_cnt = CNT_W'(0);
               if (wake_pend_ff) begin
                  nxt_cnt = (want_src == SRC_EXT) ? CNT_W'(EXT_WAKE_CYC) : WARMUP_N;
               // delay only when the oscillator is off
               end else if ((run_ff & src_osc(want_src)) == 3'h0) begin
                  nxt_cnt = start_cyc(want_src);
               end
            end
         end
         ST_STARTUP: begin
            if (cnt_ff != CNT_W'(0)) begin
               nxt_cnt = cnt_ff - CNT_W'(1);
            end else if (tgt_src_ff != SRC_PLL || pll_ready_ff) begin
               nxt_run = run_ff | src_osc(tgt_src_ff);
               nxt_state = ST_WAIT_FALL;
            end
         end
         // old clock low first, then hold low for a new rising edge
         ST_WAIT_FALL: begin
            if (!old_level) begin
               nxt_state = ST_HOLD_LOW;
               nxt_live = 1'b0;
               nxt_sys_clk = 1'b0;
            end
         end
         ST_HOLD_LOW: begin
            nxt_sys_clk = 1'b0;
            // switch only on a clean low-to-high edge
            if (new_level && !prev_new_ff) begin
               nxt_state = ST_STATUS;
               nxt_live = 1'b1;
               nxt_active_src = tgt_src_ff;
               nxt_postscale_sel = tgt_freq_ff;
               nxt_sys_clk = 1'b1;
            end
         end
         // status follows activation; idle HF, MF and LF oscillators shut down, the PLL follows its own enable
         ST_STATUS: begin
            nxt_run = src_osc(active_src_ff);
            nxt_wake_pend = 1'b0;
            nxt_state = ST_DONE;
         end
         ST_DONE: begin
            nxt_switch_busy = 1'b0;
            nxt_state = ST_IDLE;
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
      nxt_osc_enable.hf = nxt_run[2] || (nxt_switch_busy && src_osc(nxt_tgt_src) == 3'h4);
      nxt_osc_enable.mf = nxt_run[1] || (nxt_switch_busy && src_osc(nxt_tgt_src) == 3'h2);
      nxt_osc_enable.lf = nxt_run[0] || (nxt_switch_busy && src_osc(nxt_tgt_src) == 3'h1);
      nxt_osc_enable.pll = pll_on && !sleep_mode;
   end

   //////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         software_pll_enable_ff <= SW_PLL_RESET;
         internal_freq_select_ff <= FREQ_RESET;
         system_clock_select_ff <= SCS_RESET;
         pll_cnt_ff <= CNT_W'(0);
         pll_ready_ff <= 1'b0;
         state_ff <= ST_IDLE;
         tgt_src_ff <= SRC_MF;
         tgt_freq_ff <= FREQ_RESET;
         active_src_ff <= SRC_MF;
         postscale_sel_ff <= FREQ_RESET;
         run_ff <= 3'h0;
         cnt_ff <= CNT_W'(0);
         wake_pend_ff <= 1'b1;
         live_ff <= 1'b0;
         prev_new_ff <= 1'b0;
         sys_clk_ff <= 1'b0;
         switch_busy_ff <= 1'b0;
         osc_enable_ff <= '0;
      end else begin
         software_pll_enable_ff <= nxt_software_pll_enable;
         internal_freq_select_ff <= nxt_internal_freq_select;
         system_clock_select_ff <= nxt_system_clock_select;
         pll_cnt_ff <= nxt_pll_cnt;
         pll_ready_ff <= nxt_pll_ready;
         state_ff <= nxt_state;
         tgt_src_ff <= nxt_tgt_src;
         tgt_freq_ff <= nxt_tgt_freq;
         active_src_ff <= nxt_active_src;
         postscale_sel_ff <= nxt_postscale_sel;
         run_ff <= nxt_run;
         cnt_ff <= nxt_cnt;
         wake_pend_ff <= nxt_wake_pend;
         live_ff <= nxt_live;
         prev_new_ff <= nxt_prev_new;
         sys_clk_ff <= nxt_sys_clk;
         switch_busy_ff <= nxt_switch_busy;
         osc_enable_ff <= nxt_osc_enable;
      end
   end
endmodule // iocs_clock_select

// [testbench/iocs_clock_select_asserts.sv]
`timescale 1ns/10ps
module iocs_clock_select_chk #(
   parameter int PLL_LOCK_CYCLES = 8,
   parameter int WARMUP_CYCLES = 2
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [7:0] araddr,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   input wire logic sys_clk_ff,
   input wire iocs_pkg::iocs_osc_en_t osc_enable_ff,
   input wire logic [3:0] postscale_sel_ff,
   input wire iocs_pkg::iocs_src_t active_src_ff,
   input wire logic switch_busy_ff
);
   import iocs_pkg::*;
   localparam int busy_max = 300;
   logic [7:0] rd_addr_ff;
   logic [7:0] nxt_rd_addr;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   always_comb begin
      nxt_rd_addr = rd_addr_ff;
      if (arvalid && arready) begin
         nxt_rd_addr = araddr;
      end
   end
   always_ff @(posedge aclk) begin
      rd_addr_ff <= nxt_rd_addr;
   end
   function automatic logic src_ok(input iocs_src_t s, input logic [3:0] f);
      if (f[3] || f == 4'h3) return (s == SRC_HF) || (s == SRC_PLL && f == 4'he);
      if (f[3:1] == 3'h0) return s == SRC_LF;
      return s == SRC_MF;
   endfunction
   sequence sw_start;
      $rose(switch_busy_ff);
   endsequence
   // status lags the source by a cycle, so wait out the tail of a switch
   sequence quiet3;
      !switch_busy_ff && !$past(switch_busy_ff) && !$past(switch_busy_ff, 2);
   endsequence
   ////////////////////////////////////////////////////////////////
   chk_reset_freq:
      assert property ($rose(aresetn) |-> postscale_sel_ff == 4'h7 && active_src_ff == SRC_MF)
      else $error("frequency select not at reset value");
   chk_ctrl_bit2:
      assert property (rvalid && rd_addr_ff == OSC_CONTROL_OFFSET |-> rdata[2] == 1'b0)
      else $error("control bit 2 reads one");
   chk_cfg_src_bit:
      assert property (rvalid && rd_addr_ff == OSC_STATUS_OFFSET ##0 quiet3
         |-> rdata[5] == (active_src_ff == SRC_EXT))
      else $error("source status bit wrong");
   chk_freq_decode:
      assert property (!switch_busy_ff && active_src_ff != SRC_EXT
         |-> src_ok(active_src_ff, postscale_sel_ff))
      else $error("running source does not match select field");
   chk_pll_path:
      assert property (active_src_ff == SRC_PLL |-> postscale_sel_ff == 4'he && osc_enable_ff.pll)
      else $error("pll source without its setting");
   chk_idle_stable:
      assert property (!switch_busy_ff && !$past(switch_busy_ff)
         |-> $stable(active_src_ff) && $stable(postscale_sel_ff))
      else $error("source changed outside a switch");
   chk_switch_bound:
      assert property (sw_start |-> ##[1:busy_max] !switch_busy_ff)
      else $error("switch did not complete");
   // a new source only takes over on a rising edge out of the held-low phase
   chk_clk_handover:
      assert property ($changed(active_src_ff) || $changed(postscale_sel_ff)
         |-> sys_clk_ff && !$past(sys_clk_ff))
      else $error("output clock not handed over from low");
   chk_read_answer:
      assert property (arvalid && arready |=> rvalid)
      else $error("read not answered next cycle");
   chk_read_once:
      assert property (rvalid && rready |=> !rvalid)
      else $error("read answer repeated");
endmodule // iocs_clock_select_chk
bind iocs_clock_select iocs_clock_select_chk #(.PLL_LOCK_CYCLES(PLL_LOCK_CYCLES),
   .WARMUP_CYCLES(WARMUP_CYCLES)) u_chk (.aclk, .aresetn, .arvalid, .arready, .araddr,
   .rvalid, .rready, .rdata, .sys_clk_ff, .osc_enable_ff, .postscale_sel_ff, .active_src_ff,
   .switch_busy_ff);

// [testbench/iocs_clock_select_tb_top.sv]
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
   $display("BAD %0t got %h exp %h", $time, a, b); end end
module iocs_clock_select_tb_top;
   import iocs_pkg::*;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, sleep_mode, config_pll_enable;
   logic awready, wready, bvalid, arready, rvalid, sys_clk_ff, switch_busy_ff;
   logic [7:0] awaddr, araddr, rd;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb, postscale_sel_ff;
   logic [1:0] bresp, rresp, config_clock_source, resp;
   logic [2:0] tick = '0;
   iocs_levels_t osc_levels = '0;
   iocs_osc_en_t osc_enable_ff;
   iocs_src_t active_src_ff;
   int error_cnt = 0;
   int samples_checked = 0;
   int wait_n;
   logic [3:0] codes [10] = '{4'hf, 4'he, 4'hd, 4'h8, 4'h7, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0};
   iocs_src_t exp_src [10] = '{SRC_HF, SRC_HF, SRC_HF, SRC_HF, SRC_MF, SRC_MF, SRC_HF,
      SRC_MF, SRC_LF, SRC_LF};
   iocs_clock_select #(.PLL_LOCK_CYCLES(8), .WARMUP_CYCLES(2)) dut (.aclk, .aresetn, .awvalid,
      .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
      .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .config_clock_source,
      .config_pll_enable, .sleep_mode, .osc_levels, .sys_clk_ff, .osc_enable_ff,
      .postscale_sel_ff, .active_src_ff, .switch_busy_ff);
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   // source clocks at three rates (HF and PLL share one, MF and EXT another) so every edge wait really waits
   always @(posedge aclk) begin
      tick <= tick + 3'h1;
      osc_levels <= {tick[1], tick[0], tick[1], tick[2], tick[0]};
   end
   ////////////////////////////////////////////////////////////////
   // bready and rready stay high once raised; wr drives bready and rdr drives rready high again before its handshake
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      awaddr <= a;
      wdata <= {24'h0, d};
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      resp = bresp;
   endtask
   task automatic rdr(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rd = rdata[7:0];
      resp = rresp;
   endtask
   task automatic settle();
      wait_n = 0;
      repeat (3) @(posedge aclk);
      while (switch_busy_ff !== 1'b0 && wait_n < 400) begin
         @(posedge aclk);
         wait_n++;
      end
      if (wait_n >= 400) error_cnt++;
   endtask
   task automatic end_of_test();
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge aclk);
      error_cnt++;
      end_of_test();
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, sleep_mode, config_pll_enable, aresetn} = '0;
      {awaddr, araddr, wdata, wstrb, config_clock_source} = '0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      settle();
      rdr(OSC_CONTROL_OFFSET);
      `CHK(rd, 8'h38)
      `CHK(active_src_ff, SRC_MF)
      rdr(8'h08);
      `CHK(resp, RESP_SLVERR)
      wr(8'h0c, 8'hff);
      `CHK(resp, RESP_SLVERR)
      wr(OSC_CONTROL_OFFSET, 8'h7e);
      settle();
      rdr(OSC_CONTROL_OFFSET);
      `CHK(rd, 8'h7a)
      rdr(OSC_STATUS_OFFSET);
      `CHK(rd[5:4], 2'h1)
      `CHK(rd[2], 1'b0)
      foreach (codes[i]) begin
         wr(OSC_CONTROL_OFFSET, {1'b0, codes[i], 3'b010});
         settle();
         `CHK(postscale_sel_ff, codes[i])
         `CHK(active_src_ff, exp_src[i])
         if (i == 1) `CHK(wait_n < HF_START_CYC, 1'b1)
         if (i == 6) `CHK(wait_n > 10, 1'b1)
      end
      wr(OSC_CONTROL_OFFSET, 8'hf0);
      settle();
      `CHK(active_src_ff, SRC_PLL)
      rdr(OSC_STATUS_OFFSET);
      `CHK(rd[6], 1'b1)
      config_pll_enable <= 1'b1;
      wr(OSC_CONTROL_OFFSET, 8'h70);
      settle();
      `CHK(active_src_ff, SRC_PLL)
      wr(OSC_CONTROL_OFFSET, 8'hf2);
      settle();
      `CHK(active_src_ff, SRC_HF)
      config_pll_enable <= 1'b0;
      config_clock_source <= 2'h1;
      wr(OSC_CONTROL_OFFSET, 8'h38);
      settle();
      `CHK(active_src_ff, SRC_EXT)
      rdr(OSC_STATUS_OFFSET);
      `CHK(rd[5], 1'b1)
      wr(OSC_CONTROL_OFFSET, 8'h39);
      settle();
      `CHK(active_src_ff, SRC_EXT)
      sleep_mode <= 1'b1;
      repeat (5) @(posedge aclk);
      // asleep: output clock parked low and every oscillator off
      `CHK(sys_clk_ff, 1'b0)
      `CHK(osc_enable_ff, 4'h0)
      sleep_mode <= 1'b0;
      settle();
      `CHK(active_src_ff, SRC_EXT)
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      settle();
      rdr(OSC_CONTROL_OFFSET);
      `CHK(rd, 8'h38)
      end_of_test();
   end
endmodule // iocs_clock_select_tb_top
